/* design/ssrw_pkg.sv */
// ssrw_pkg: shared constants of the supply supervisor, reset and watchdog block
// assumes a single 200 MHz clock and comparator results already digital
package ssrw_pkg;

   // clock rate
   localparam int CLK_MHZ = 200; // core clock in MHz
   localparam int CLK_PERIOD_NS = 5; // core clock period

   // counter width shared by every timer
   localparam int TMR_W = 32; // wide enough for the watchdog count

   // reset stretch after the last reset cause goes away
   localparam int RST_STRETCH_MS = 200; // stretch time in ms
   localparam logic [31:0] RST_STRETCH_CYC = 32'(RST_STRETCH_MS * CLK_MHZ * 1000);

   // chip-enable hold after reset asserts
   localparam int CE_HOLD_US = 10; // hold time in us
   localparam logic [31:0] CE_HOLD_CYC = 32'(CE_HOLD_US * CLK_MHZ);

   // watchdog timeout, 1.6 s
   localparam int WD_TIMEOUT_MS = 1600; // timeout in ms
   localparam logic [31:0] WD_TIMEOUT_CYC = 32'(WD_TIMEOUT_MS * CLK_MHZ * 1000);

   // reset values of the registered outputs
   localparam logic RST_VAL_RESET_N = 1'b0; // reset asserted out of reset
   localparam logic RST_VAL_FAULT_N = 1'b1; // no watchdog fault
   localparam logic RST_VAL_CE_N = 1'b1; // memory deselected
   localparam logic RST_VAL_PFO = 1'b0; // power fail shown until inputs seen
   localparam logic RST_VAL_EW_N = 1'b0; // early warning shown until seen
   localparam logic RST_VAL_CELL = 1'b0; // cell not routed

endpackage

/* design/ssrw_timer.sv */
// ssrw_timer: loadable down counter with a zero flag
// assumes load and run come from the same clock domain
`timescale 1ns/1ps
module ssrw_timer
   import ssrw_pkg::*;
#(
   parameter logic [TMR_W-1:0] RST_VAL = '0
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic run_i,
   input wire logic [TMR_W-1:0] load_val_i,
   output logic [TMR_W-1:0] count_o,
   output logic done_o
);

   logic [TMR_W-1:0] cnt_reg; // remaining cycles

   // load wins over counting; stops at zero
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cnt_reg <= RST_VAL;
      end else if (load_i) begin
         cnt_reg <= load_val_i;
      end else if (run_i && (cnt_reg != '0)) begin
         cnt_reg <= cnt_reg - 1'b1;
      end
   end

   assign count_o = cnt_reg;
   assign done_o = (cnt_reg == '0);

endmodule

/* design/ssrw_edge.sv */
// ssrw_edge: rise and any-edge detector on a synchronous level
// assumes the input is already synchronous to mclk_i
`timescale 1ns/1ps
module ssrw_edge #(
   parameter logic RST_LVL = 1'b0 // idle level of the watched signal out of reset
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic in_i,
   output logic rise_o,
   output logic any_o
);

   logic prev_reg; // level one cycle ago

   // delay stage
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         prev_reg <= RST_LVL;
      end else begin
         prev_reg <= in_i;
      end
   end

   // edges are one-cycle pulses
   assign rise_o = in_i & ~prev_reg;
   assign any_o = in_i ^ prev_reg;

endmodule

/* design/ssrw_top.sv */
// ssrw_top: supply supervisor with reset stretch, watchdog and chip-enable gating
// assumes every comparator result and pin input is synchronous to mclk_i
`timescale 1ns/1ps
module ssrw_top
   import ssrw_pkg::*;
#(
   parameter logic [TMR_W-1:0] STRETCH_CYC = RST_STRETCH_CYC,
   parameter logic [TMR_W-1:0] WD_CYC = WD_TIMEOUT_CYC
) (
   input wire logic mclk_i,
   input wire logic rst_i,
   input wire logic vcc_above_rst_i,
   input wire logic vcc_above_sw_i,
   input wire logic vcc_above_cell_i,
   input wire logic vcc_above_early_warning_i,
   input wire logic power_fail_sense_in_i,
   input wire logic cell_good_level_i,
   input wire logic manual_reset_n_i,
   input wire logic watchdog_kick_in_i,
   input wire logic chip_enable_n_i,
   output logic ram_from_cell_o,
   output logic backup_switch_indicator_o,
   output logic cell_status_good_o,
   output logic power_fail_flag_out_o,
   output logic early_warning_n_o,
   output logic reset_n_o,
   output logic reset_n_oe_n_o,
   output logic reset_o,
   output logic watchdog_fault_n_o,
   output logic chip_enable_gated_n_o
);

   // hold length bound for the checks below
   localparam logic [TMR_W-1:0] CE_MAX = CE_HOLD_CYC + 32'd2; // ce hold length plus margin

   // internal state
   logic ram_from_cell_reg; // ram supply taken from the cell
   logic cell_status_reg; // cell status pin
   logic pfo_reg; // power-fail flag pin
   logic ew_n_reg; // early warning pin
   logic rst_act_reg; // internal reset asserted
   logic rst_act_next; // next internal reset state
   logic reset_n_reg; // active-low reset pin
   logic reset_reg; // active-high reset pin
   logic fault_n_reg; // watchdog fault pin
   logic ce_hold_reg; // chip enable still passed through
   logic ce_hold_next; // next hold state
   logic ce_n_reg; // gated chip enable pin
   logic cell_set; // conditions to move to the cell
   logic cell_clr; // conditions to move back to main

   // reset cause and timer outputs
   logic rst_cause; // supply low or manual reset pressed
   logic [TMR_W-1:0] stretch_cnt; // stretch cycles left
   logic stretch_done; // stretch elapsed
   logic [TMR_W-1:0] wd_cnt; // watchdog cycles left
   logic wd_done; // watchdog ran out
   logic wd_load; // clears the watchdog timer
   logic [TMR_W-1:0] ce_cnt; // ce hold cycles left
   logic ce_done; // ce hold elapsed
   logic kick_any; // any edge of the watchdog input
   logic rst_rise; // internal reset just asserted

   // backup source selection
   // switch conditions
   assign cell_set = ~vcc_above_sw_i & ~vcc_above_cell_i;
   assign cell_clr = vcc_above_rst_i | vcc_above_cell_i;

   // source latch, in between thresholds the last source stays
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ram_from_cell_reg <= RST_VAL_CELL;
      end else if (cell_set) begin
         ram_from_cell_reg <= 1'b1;
      end else if (cell_clr) begin
         ram_from_cell_reg <= 1'b0;
      end
   end

   // cell status, only meaningful above the switch threshold
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cell_status_reg <= 1'b0;
      end else begin
         cell_status_reg <= vcc_above_sw_i & cell_good_level_i;
      end
   end

   // power-fail and early warning flags
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         pfo_reg <= RST_VAL_PFO;
         ew_n_reg <= RST_VAL_EW_N;
      end else begin
         pfo_reg <= power_fail_sense_in_i & vcc_above_sw_i;
         ew_n_reg <= vcc_above_early_warning_i;
      end
   end

   // reset generation
   // reset cause terms
   assign rst_cause = ~vcc_above_rst_i | ~manual_reset_n_i;

   // stretch timer reloads on each cause
   ssrw_timer #(
      .RST_VAL(STRETCH_CYC)
   ) u_stretch (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .load_i(rst_cause),
      .run_i(~rst_cause),
      .load_val_i(STRETCH_CYC),
      .count_o(stretch_cnt),
      .done_o(stretch_done)
   );

   // held by cause, then by stretch
   assign rst_act_next = rst_cause | ~stretch_done;

   // reset pins; reset_o driven both ways, reset_n_o open drain via reset_n_oe_n_o
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         rst_act_reg <= 1'b1;
         reset_n_reg <= RST_VAL_RESET_N;
         reset_reg <= ~RST_VAL_RESET_N;
      end else begin
         rst_act_reg <= rst_act_next;
         reset_n_reg <= ~rst_act_next;
         reset_reg <= rst_act_next;
      end
   end

   // watchdog
   ssrw_edge u_kick_edge (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .in_i(watchdog_kick_in_i),
      .rise_o(),
      .any_o(kick_any)
   );

   assign wd_load = rst_act_reg | kick_any;

   ssrw_timer #(
      .RST_VAL(WD_CYC)
   ) u_wdog (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .load_i(wd_load),
      .run_i(~rst_act_reg),
      .load_val_i(WD_CYC),
      .count_o(wd_cnt),
      .done_o(wd_done)
   );

   // fault pin; a kick in the expiry cycle wins, so no stale fault
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         fault_n_reg <= RST_VAL_FAULT_N;
      end else if (~vcc_above_sw_i) begin
         fault_n_reg <= 1'b0;
      end else if (rst_act_reg) begin
         fault_n_reg <= 1'b1;
      end else if (kick_any) begin
         fault_n_reg <= 1'b1;
      end else if (wd_done) begin
         fault_n_reg <= 1'b0;
      end
   end

   // chip-enable gating; internal reset is high out of rst_i, so no false rise
   ssrw_edge #(.RST_LVL(1'b1)) u_rst_edge (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .in_i(rst_act_reg),
      .rise_o(rst_rise),
      .any_o()
   );

   ssrw_timer #(
      .RST_VAL('0)
   ) u_ce_hold (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .load_i(rst_rise),
      .run_i(1'b1),
      .load_val_i(CE_HOLD_CYC),
      .count_o(ce_cnt),
      .done_o(ce_done)
   );

   // hold keeps an access that began before reset alive briefly
   always_comb begin
      ce_hold_next = ce_hold_reg;
      if (rst_rise) begin
         // only if the access is open
         ce_hold_next = ~chip_enable_n_i;
      end else if (chip_enable_n_i || ce_done) begin
         ce_hold_next = 1'b0;
      end
   end

   // hold state and gated pin
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         ce_hold_reg <= 1'b0;
         ce_n_reg <= RST_VAL_CE_N;
      end else begin
         ce_hold_reg <= ce_hold_next;
         ce_n_reg <= chip_enable_n_i | (rst_act_reg & ~ce_hold_next);
      end
   end

   // outputs, all straight from flops
   assign ram_from_cell_o = ram_from_cell_reg;
   assign backup_switch_indicator_o = ram_from_cell_reg;
   assign cell_status_good_o = cell_status_reg;
   assign power_fail_flag_out_o = pfo_reg;
   assign early_warning_n_o = ew_n_reg;
   assign reset_n_o = reset_n_reg;
   // open drain: enable low only while pulling low
   assign reset_n_oe_n_o = reset_n_reg;
   assign reset_o = reset_reg;
   assign watchdog_fault_n_o = fault_n_reg;
   assign chip_enable_gated_n_o = ce_n_reg;

   logic [TMR_W-1:0] hold_len_reg; // cycles the current hold has lasted

   // check helper; counts instead of a delay range too long for the tools
   always_ff @(posedge mclk_i) begin
      if (rst_i || !ce_hold_reg) begin
         hold_len_reg <= '0;
      end else begin
         hold_len_reg <= hold_len_reg + 1'b1;
      end
   end

   // checks
   sequence s_reset_starts;
      $rose(rst_act_reg) && !chip_enable_n_i;
   endsequence

   sequence s_hold_ends;
      hold_len_reg < CE_MAX;
   endsequence

   chk_cell_route: assert property (@(posedge mclk_i) disable iff (rst_i)
      cell_set |=> ram_from_cell_o)
      else $error("ram supply not moved to the cell");

   chk_indicator_follow: assert property (@(posedge mclk_i) disable iff (rst_i)
      backup_switch_indicator_o == ram_from_cell_o)
      else $error("indicator differs from supply source");

   chk_indicator_release: assert property (@(posedge mclk_i) disable iff (rst_i)
      (cell_clr && !cell_set) |=> !backup_switch_indicator_o)
      else $error("indicator not released on main supply");

   chk_cell_status: assert property (@(posedge mclk_i) disable iff (rst_i)
      (vcc_above_sw_i && !rst_i) |=> cell_status_good_o == $past(cell_good_level_i))
      else $error("cell status does not follow cell level");

   chk_cell_low_sw: assert property (@(posedge mclk_i) disable iff (rst_i)
      !vcc_above_sw_i |=> !cell_status_good_o)
      else $error("cell status high below switch threshold");

   chk_power_fail_flag: assert property (@(posedge mclk_i) disable iff (rst_i)
      !rst_i |=> power_fail_flag_out_o == ($past(power_fail_sense_in_i) && $past(vcc_above_sw_i)))
      else $error("power-fail flag wrong");

   chk_early_warning: assert property (@(posedge mclk_i) disable iff (rst_i)
      !vcc_above_early_warning_i |=> !early_warning_n_o)
      else $error("early warning not low");

   chk_manual_reset: assert property (@(posedge mclk_i) disable iff (rst_i)
      !manual_reset_n_i |=> !reset_n_o && reset_o)
      else $error("manual reset did not assert reset");

   chk_supply_reset: assert property (@(posedge mclk_i) disable iff (rst_i)
      !vcc_above_rst_i |=> !reset_n_o)
      else $error("low supply did not hold reset");

   chk_stretch_release: assert property (@(posedge mclk_i) disable iff (rst_i)
      $rose(reset_n_o) |-> $past(stretch_done) && $past(vcc_above_rst_i) && $past(manual_reset_n_i))
      else $error("reset released before stretch elapsed");

   chk_stretch_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
      $fell(rst_cause) |=> !reset_n_o [*2])
      else $error("reset released without stretch");

   chk_reset_inverse: assert property (@(posedge mclk_i) disable iff (rst_i)
      reset_o == !reset_n_o)
      else $error("reset outputs not inverse");

   chk_wd_fault: assert property (@(posedge mclk_i) disable iff (rst_i)
      (wd_done && !rst_act_reg && !kick_any && vcc_above_sw_i) |=> !watchdog_fault_n_o)
      else $error("watchdog fault missed");

   chk_wd_recover: assert property (@(posedge mclk_i) disable iff (rst_i)
      (kick_any && vcc_above_sw_i) |=> watchdog_fault_n_o)
      else $error("fault not cleared by transition");

   chk_wd_low_sw: assert property (@(posedge mclk_i) disable iff (rst_i)
      !vcc_above_sw_i |=> !watchdog_fault_n_o)
      else $error("fault pin high below switch threshold");

   chk_wd_timeout: assert property (@(posedge mclk_i) disable iff (rst_i)
      $past(wd_load) && !wd_load |-> wd_cnt == WD_CYC)
      else $error("watchdog not loaded with timeout");

   chk_wd_cleared: assert property (@(posedge mclk_i) disable iff (rst_i)
      rst_act_reg [*2] |-> wd_cnt == WD_CYC)
      else $error("watchdog counted during reset");

   chk_stretch_restart: assert property (@(posedge mclk_i) disable iff (rst_i)
      !vcc_above_rst_i |=> stretch_cnt == STRETCH_CYC)
      else $error("stretch timer not restarted");

   chk_ce_gate: assert property (@(posedge mclk_i) disable iff (rst_i)
      (!chip_enable_n_i && !rst_act_reg) |=> !chip_enable_gated_n_o)
      else $error("gated enable not passed");

   chk_ce_hold_start: assert property (@(posedge mclk_i) disable iff (rst_i)
      s_reset_starts |=> !chip_enable_gated_n_o && ce_hold_reg)
      else $error("open access cut at reset");

   chk_ce_hold_end: assert property (@(posedge mclk_i) disable iff (rst_i)
      ce_hold_reg |-> s_hold_ends)
      else $error("chip enable held too long");

endmodule

/* tb/ssrw_cpu_model.sv */
// ssrw_cpu_model: processor side of the supervisor, kicks the watchdog and drives memory select
// assumes mclk_i is the supervisor clock and inputs change just after its rising edge
`timescale 1ns/1ps
module ssrw_cpu_model #(
   parameter int KICK_GAP = 20 // cycles between kicks, well below the timeout
) (
   input wire logic mclk_i,
   input wire logic run_i,
   input wire logic pulse_i,
   input wire logic ce_req_i,
   output logic watchdog_kick_in_o,
   output logic chip_enable_n_o
);
   int gap_cnt; // cycles since the last free-running kick
   initial begin
      watchdog_kick_in_o = 1'b0;
      chip_enable_n_o = 1'b1;
      gap_cnt = 0;
   end
   // free-running kicks plus single commanded toggles
   always @(posedge mclk_i) begin
      gap_cnt <= (run_i && gap_cnt < KICK_GAP - 1) ? gap_cnt + 1 : 0;
      if (pulse_i || (run_i && gap_cnt == KICK_GAP - 1)) begin
         watchdog_kick_in_o <= ~watchdog_kick_in_o;
      end
      // memory select follows the request a cycle late
      chip_enable_n_o <= ~ce_req_i;
   end
endmodule

/* tb/ssrw_top_tb.sv */
// ssrw_top_tb: self-checking bench for the supervisor with a processor model on its far side
// assumes the design accepts shortened stretch and watchdog counts
`timescale 1ns/1ps
module ssrw_top_tb;
   import ssrw_pkg::*;
   localparam logic [TMR_W-1:0] N_STR = 32'h14; // shortened stretch, 20 cycles
   localparam logic [TMR_W-1:0] N_WD = 32'h32; // shortened timeout, 50 cycles
   localparam int STR = 20;
   localparam int WD = 50;
   localparam int LIMIT = 20000; // whole run needs about 2900 cycles
   logic mclk_i, rst_i, a_rst, a_sw, a_cell, a_ew, pf_sense, cell_good, mr_n, run, pulse, ce_req;
   logic kick, ce_n, route, ind, cst, power_fail_flag_out, ew_n, rst_n, rst_oe_n, rst_hi, fault_n, ce_gated_n;
   int errors = 0;
   int samples_checked = 0;
   int cyc = 0;
   int n;
   // truth table: rst sw cell ew sense good expected_route
   logic [6:0] tbl [7] = '{7'h7e, 7'h70, 7'h0f, 7'h2f, 7'h1e, 7'h0f, 7'h60};
   ssrw_cpu_model cpu (.mclk_i(mclk_i), .run_i(run), .pulse_i(pulse), .ce_req_i(ce_req),
      .watchdog_kick_in_o(kick), .chip_enable_n_o(ce_n));
   ssrw_top #(.STRETCH_CYC(N_STR), .WD_CYC(N_WD)) dut (.mclk_i(mclk_i), .rst_i(rst_i),
      .vcc_above_rst_i(a_rst), .vcc_above_sw_i(a_sw), .vcc_above_cell_i(a_cell),
      .vcc_above_early_warning_i(a_ew), .power_fail_sense_in_i(pf_sense), .cell_good_level_i(cell_good),
      .manual_reset_n_i(mr_n), .watchdog_kick_in_i(kick), .chip_enable_n_i(ce_n),
      .ram_from_cell_o(route), .backup_switch_indicator_o(ind), .cell_status_good_o(cst),
      .power_fail_flag_out_o(power_fail_flag_out), .early_warning_n_o(ew_n), .reset_n_o(rst_n),
      .reset_n_oe_n_o(rst_oe_n), .reset_o(rst_hi), .watchdog_fault_n_o(fault_n),
      .chip_enable_gated_n_o(ce_gated_n));
   // free-running clock, 5 ns period
   initial begin
      mclk_i = 1'b0;
      forever #2.5 mclk_i = ~mclk_i;
   end
   task automatic check_bit(input logic got, input logic exp);
      samples_checked++;
      if (got !== exp) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic check_cnt(input int got, input int exp);
      samples_checked++;
      if (got != exp) begin
         errors++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic print_verdict();
      if (errors == 0 && samples_checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // edges after the current one until the chosen output reaches lvl, capped at max
   task automatic count_until(input int w, input logic lvl, input int max, output int cnt);
      logic v;
      cnt = 0;
      do begin
         @(posedge mclk_i);
         cnt++;
         @(negedge mclk_i);
         v = (w == 0) ? rst_n : (w == 1) ? fault_n : ce_gated_n;
      end while (v !== lvl && cnt < max);
   endtask
   // wait k edges then look at settled outputs
   task automatic look(input int k);
      repeat (k) @(posedge mclk_i);
      @(negedge mclk_i);
   endtask
   // hang guard
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      if (cyc == LIMIT) begin
         errors++;
         print_verdict();
      end
   end
   // both reset polarities watched every cycle while rst_i is low
   always @(negedge mclk_i) begin
      if (!rst_i) begin
         check_bit(rst_hi, ~rst_n);
         check_bit(rst_oe_n, rst_n);
      end
   end
   task automatic s_flags();
      for (int i = 0; i < 7; i++) begin
         @(posedge mclk_i);
         {a_rst, a_sw, a_cell, a_ew, pf_sense, cell_good} <= tbl[i][6:1];
         look(2);
         check_bit(route, tbl[i][0]);
         check_bit(ind, tbl[i][0]);
         check_bit(cst, tbl[i][5] & tbl[i][1]);
         check_bit(power_fail_flag_out, tbl[i][5] & tbl[i][2]);
         check_bit(ew_n, tbl[i][3]);
      end
      @(posedge mclk_i);
      {a_rst, a_sw, a_cell, a_ew, pf_sense, cell_good} <= 6'h3f;
      look(STR + 5);
   endtask
   task automatic s_reset();
      @(posedge mclk_i);
      mr_n <= 1'b0;
      look(3);
      check_bit(rst_n, 1'b0);
      @(posedge mclk_i);
      mr_n <= 1'b1;
      count_until(0, 1'b1, 200, n);
      check_cnt(n, STR + 1);
      @(posedge mclk_i);
      mr_n <= 1'b0;
      @(posedge mclk_i);
      mr_n <= 1'b1;
      repeat (10) @(posedge mclk_i);
      a_rst <= 1'b0;
      @(posedge mclk_i);
      a_rst <= 1'b1;
      count_until(0, 1'b1, 200, n);
      check_cnt(n, STR + 1);
   endtask
   task automatic s_watchdog();
      @(posedge mclk_i);
      run <= 1'b1;
      count_until(1, 1'b0, 300, n);
      check_cnt(n, 300);
      @(posedge mclk_i);
      run <= 1'b0;
      pulse <= 1'b1;
      @(posedge mclk_i);
      pulse <= 1'b0;
      count_until(1, 1'b0, 200, n);
      check_cnt(n, WD + 2);
      @(posedge mclk_i);
      pulse <= 1'b1;
      @(posedge mclk_i);
      pulse <= 1'b0;
      count_until(1, 1'b1, 20, n);
      check_cnt(n, 1);
      @(posedge mclk_i);
      mr_n <= 1'b0;
      count_until(1, 1'b0, WD + 20, n);
      check_cnt(n, WD + 20);
      @(posedge mclk_i);
      mr_n <= 1'b1;
      count_until(1, 1'b0, STR + WD, n);
      check_cnt(n, STR + WD);
      count_until(1, 1'b0, 20, n);
      check_bit(fault_n, 1'b0);
      @(posedge mclk_i);
      {a_rst, a_sw} <= 2'h0;
      pulse <= 1'b1;
      @(posedge mclk_i);
      pulse <= 1'b0;
      look(3);
      check_bit(fault_n, 1'b0);
      @(posedge mclk_i);
      a_sw <= 1'b1;
      look(3);
      check_bit(fault_n, 1'b1);
      @(posedge mclk_i);
      a_rst <= 1'b1;
      look(STR + 5);
   endtask
   task automatic s_chip_enable();
      @(posedge mclk_i);
      ce_req <= 1'b1;
      look(3);
      check_bit(ce_gated_n, 1'b0);
      @(posedge mclk_i);
      mr_n <= 1'b0;
      count_until(2, 1'b1, 2100, n);
      // gated select survives 10 us into reset
      check_bit(n >= 2000 && n <= 2006, 1'b1);
      @(posedge mclk_i);
      mr_n <= 1'b1;
      look(STR + 5);
      check_bit(ce_gated_n, 1'b0);
      @(posedge mclk_i);
      mr_n <= 1'b0;
      look(100);
      check_bit(ce_gated_n, 1'b0);
      @(posedge mclk_i);
      ce_req <= 1'b0;
      count_until(2, 1'b1, 10, n);
      check_bit(n <= 3, 1'b1);
      @(posedge mclk_i);
      mr_n <= 1'b1;
      look(STR + 5);
      check_bit(ce_gated_n, 1'b1);
   endtask
   // main sequence
   initial begin
      rst_i = 1'b1;
      {a_rst, a_sw, a_cell, a_ew, pf_sense, cell_good} = 6'h3f;
      mr_n = 1'b1;
      run = 1'b0;
      pulse = 1'b0;
      ce_req = 1'b0;
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      look(STR + 5);
      s_flags();
      s_reset();
      s_watchdog();
      s_chip_enable();
      print_verdict();
   end
endmodule
